// [dv/host_capture_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_capture_model (
	output logic      o_readout_clock,
	input  wire logic i_first_lane,
	input  wire logic i_second_lane
);
	// ====
	// readout burst
	initial o_readout_clock = 1'b0;
	// clock idles low between bursts; lanes read just before each edge but the last dual-lane one,
	// settled since the previous echoed edge
	task automatic read_word(input logic dual, output logic [17:0] word);
		int n;
		n = dual ? 10 : 18;
		word = 18'h0;
		#7;
		for (int e = 0; e < n; e++) begin
			#80;
			if (!dual)
				word = {word[16:0], i_first_lane};
			else if (e < 9)
				word = {word[15:0], i_first_lane, i_second_lane};
			o_readout_clock = ~o_readout_clock;
		end
		// burst length keeps the return on a falling bench clock edge
		#73;
	endtask
endmodule
`default_nettype wire

// [dv/sar_adc_lvds_readout_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_lvds_readout_chk #(
	parameter int RESULT_BITS = 18
) (
	input wire logic                   i_clock,
	input wire logic                   i_rstn,
	input wire logic                   i_convert_strobe,
	input wire logic                   i_readout_clock,
	input wire logic                   i_dual_lane_select,
	input wire logic                   i_fixed_pattern_select,
	input wire logic [RESULT_BITS-1:0] i_sample_code,
	input wire logic                   i_sample_valid,
	input wire logic                   o_sample_ready,
	input wire logic                   o_convert_done,
	input wire logic                   o_result_invalid,
	input wire logic                   o_echo_clock_out,
	input wire logic                   o_first_lane_out,
	input wire logic                   o_second_lane_enable,
	input wire logic                   o_powered
);
	// ====
	// results since wake, saturating
	logic [1:0] n_done;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			n_done <= 2'h0;
		else if (!o_powered)
			n_done <= 2'h0;
		else if (o_convert_done && n_done != 2'h3)
			n_done <= n_done + 2'h1;
	end
	a_sleep_no_done: assert property (!o_powered |-> !o_convert_done)
		else $error("done while asleep");
	a_sleep_lanes_off: assert property (!o_powered [*2] |->
		!o_first_lane_out && !o_echo_clock_out) else $error("lane on in sleep");
	a_strobe_to_done: assert property (
		$rose(i_convert_strobe) && o_sample_ready |-> ##[7:9] o_convert_done)
		else $error("no done after strobe");
	a_msb_at_done: assert property (o_convert_done |-> o_first_lane_out ==
		(i_fixed_pattern_select | i_sample_code[RESULT_BITS-1]))
		else $error("msb wrong at done");
	a_echo_follows: assert property ($changed(i_readout_clock) && o_powered
		|-> ##[1:4] o_echo_clock_out == i_readout_clock) else $error("no echo");
	a_lane_on_edge: assert property (o_powered && $changed(o_first_lane_out)
		|-> $changed(o_echo_clock_out) || o_convert_done)
		else $error("lane moved off edge");
	a_single_lane_oe: assert property (!i_dual_lane_select [*3]
		|-> o_second_lane_enable) else $error("second lane driven");
	a_invalid_count: assert property ($past(o_convert_done) |->
		o_result_invalid == (n_done < 2'h3)) else $error("invalid flag wrong");
	a_ready_valid: assert property (o_sample_ready |->
		i_sample_valid && o_powered) else $error("ready without sample");
	// a load may slip one cycle behind a readout clock edge
	a_busy_refuses: assert property (o_convert_done |->
		!$past(o_sample_ready, 2) || !$past(o_sample_ready, 3))
		else $error("ready during conversion");
	c_dual: cover property (o_convert_done && i_dual_lane_select);
	c_pattern: cover property (o_convert_done && i_fixed_pattern_select);
	c_sleep: cover property ($fell(o_powered));
endmodule
`default_nettype wire

// [dv/sar_adc_lvds_readout_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_lvds_readout_tb;
	// ====
	// stimulus and checks
	logic        clk = 1'b0, rstn = 1'b0, sleep_n = 1'b0, strobe = 1'b0;
	logic        dual = 1'b0, fixed = 1'b0, valid = 1'b1;
	logic [17:0] code = 18'h0, word;
	logic        rclk, done, inval, echo, la, lb, oe_n, powered, ready;
	wire         lb_wire = oe_n ? ~lb : lb;
	int          err_total = 0, n_compared = 0;
	sar_adc_lvds_readout i_dut (.i_clock(clk), .i_rstn(rstn),
		.i_sleep_request_n(sleep_n), .i_convert_strobe(strobe),
		.i_readout_clock(rclk), .i_dual_lane_select(dual),
		.i_fixed_pattern_select(fixed), .i_sample_code(code),
		.i_sample_valid(valid), .o_sample_ready(ready), .o_convert_done(done),
		.o_result_invalid(inval), .o_echo_clock_out(echo),
		.o_first_lane_out(la), .o_second_lane_out(lb),
		.o_second_lane_enable(oe_n), .o_powered(powered));
	host_capture_model i_host (.o_readout_clock(rclk), .i_first_lane(la),
		.i_second_lane(lb_wire));
	task automatic chk(input logic [17:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// strobe spacing stays well under the conversion rate limit
	task automatic conv(input logic [17:0] c);
		@(negedge clk);
		code = c;
		strobe = 1'b1;
		repeat (2) @(negedge clk);
		strobe = 1'b0;
		for (int i = 0; i < 20 && done !== 1'b1; i++)
			@(negedge clk);
	endtask
	task automatic t_single();
		logic [17:0] c [3] = '{18'h2A5C3, 18'h1FFFF, 18'h20001};
		for (int k = 0; k < 3; k++) begin
			conv(c[k]);
			chk(18'(done), 18'h1);
			@(negedge clk);
			chk(18'(inval), 18'(k < 2));
			i_host.read_word(1'b0, word);
			chk(word, c[k]);
		end
		$display("single lane test finished");
	endtask
	task automatic t_dual_pattern();
		dual = 1'b1;
		conv(18'h35A96);
		chk(18'(oe_n), 18'h0);
		i_host.read_word(1'b1, word);
		chk(word, 18'h35A96);
		fixed = 1'b1;
		for (int d = 0; d < 2; d++) begin
			dual = d[0];
			conv(18'h00000);
			i_host.read_word(dual, word);
			chk(word, d ? 18'h330FC : 18'h281FC);
		end
		fixed = 1'b0;
		dual = 1'b0;
		$display("dual lane and pattern test finished");
	endtask
	task automatic t_overlap();
		conv(18'h0F0F0);
		fork
			i_host.read_word(1'b0, word);
			begin
				#1370;
				conv(18'h3C3C3);
			end
		join
		chk(word, 18'h0F0F0);
		i_host.read_word(1'b0, word);
		chk(word, 18'h3C3C3);
		$display("overlap test finished");
	endtask
	task automatic t_sleep();
		sleep_n = 1'b0;
		repeat (6) @(negedge clk);
		chk(18'(powered), 18'h0);
		conv(18'h12345);
		chk(18'(done), 18'h0);
		// settling is far longer than the run: only the flag is judged
		sleep_n = 1'b1;
		repeat (10) @(negedge clk);
		conv(18'h12345);
		@(negedge clk);
		chk(18'(inval), 18'h1);
		$display("sleep test finished");
	endtask
	task automatic t_reset();
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		chk(18'({powered, inval, la, echo}), 18'h4);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		chk(18'(powered), 18'h1);
		conv(18'h2A5C3);
		@(negedge clk);
		chk(18'(inval), 18'h1);
		$display("reset test finished");
	endtask
	initial forever #10 clk = ~clk;
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		chk(18'({powered, inval, la, echo}), 18'h4);
		sleep_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(18'(powered), 18'h1);
		t_single();
		t_dual_pattern();
		t_overlap();
		t_sleep();
		t_reset();
		conclude();
	end
	initial begin
		#100000;
		err_total++;
		conclude();
	end
endmodule
bind sar_adc_lvds_readout sar_adc_lvds_readout_chk #(
	.RESULT_BITS(RESULT_BITS)) i_chk (.i_clock, .i_rstn, .i_convert_strobe,
	.i_readout_clock, .i_dual_lane_select, .i_fixed_pattern_select,
	.i_sample_code, .i_sample_valid, .o_sample_ready, .o_convert_done,
	.o_result_invalid, .o_echo_clock_out, .o_first_lane_out,
	.o_second_lane_enable, .o_powered);
`default_nettype wire

// [rtl/result_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	input  wire logic             i_clock,
	input  wire logic             i_rstn,
	input  wire logic             i_clear,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              full  = (wr_ptr ^ rd_ptr) == {1'b1, {AW{1'b0}}};
	wire              empty = wr_ptr == rd_ptr;
	wire              push  = i_in_valid && !full;
	wire              pop   = i_out_ready && !empty;

	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge i_clock) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= i_in_data;
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (i_clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// [rtl/sar_adc_lvds_readout.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sar_readout_params.svh"
module sar_adc_lvds_readout #(
	parameter int RESULT_BITS = `RESULT_BITS,
	parameter int FIFO_DEPTH  = `FIFO_DEPTH
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rstn,
	input  wire logic                   i_sleep_request_n,
	input  wire logic                   i_convert_strobe,
	input  wire logic                   i_readout_clock,
	input  wire logic                   i_dual_lane_select,
	input  wire logic                   i_fixed_pattern_select,
	input  wire logic [RESULT_BITS-1:0] i_sample_code,
	input  wire logic                   i_sample_valid,
	output logic                        o_sample_ready,
	output logic                        o_convert_done,
	output logic                        o_result_invalid,
	output logic                        o_echo_clock_out,
	output logic                        o_first_lane_out,
	output logic                        o_second_lane_out,
	output logic                        o_second_lane_enable,
	output logic                        o_powered
);
	initial begin
		if (RESULT_BITS != `RESULT_BITS)
			$error("result width fixed at eighteen bits");
	end

	// ======================================================
	// input synchronisers
	// ======================================================
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       sleep_n;
	logic       convert_strobe;
	logic       cnv_d;
	logic       rclk;
	logic       rclk_d;
	logic       dual;
	logic       pat;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {i_sleep_request_n, i_convert_strobe, i_readout_clock};
			sync_b <= sync_a;
		end
	end
	assign sleep_n = sync_b[2];
	assign convert_strobe     = sync_b[1];
	assign rclk    = sync_b[0];

	// mode pins are static straps; synchronised the same way
	logic [1:0] mode_a;
	logic [1:0] mode_b;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_a <= 2'h0;
			mode_b <= 2'h0;
		end else begin
			mode_a <= {i_dual_lane_select, i_fixed_pattern_select};
			mode_b <= mode_a;
		end
	end
	assign dual = mode_b[1];
	assign pat  = mode_b[0];

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cnv_d  <= 1'b0;
			rclk_d <= 1'b0;
		end else begin
			cnv_d  <= convert_strobe;
			rclk_d <= rclk;
		end
	end
	wire cnv_rise  = convert_strobe && !cnv_d;
	wire rclk_edge = rclk ^ rclk_d;

	// ======================================================
	// conversion control
	// ======================================================
	sar_readout_pkg::conv_state_e state;
	sar_readout_pkg::conv_state_e next_state;
	logic [2:0] conv_count;
	logic [1:0] invalid_left;

	wire start_conv = cnv_rise && o_sample_ready;
	wire conv_end   = (state == sar_readout_pkg::ST_CONVERT)
		&& (conv_count == 3'(`CONV_CYCLES - 1));

	always_comb begin
		next_state = state;
		case (state)
			sar_readout_pkg::ST_SLEEP:
				if (sleep_n)
					next_state = sar_readout_pkg::ST_IDLE;
			sar_readout_pkg::ST_IDLE:
				if (start_conv)
					next_state = sar_readout_pkg::ST_CONVERT;
			sar_readout_pkg::ST_CONVERT:
				if (conv_end)
					next_state = sar_readout_pkg::ST_IDLE;
			default:
				next_state = sar_readout_pkg::ST_SLEEP;
		endcase
		if (!sleep_n)
			next_state = sar_readout_pkg::ST_SLEEP;
	end

	// power-on reset starts asleep and counts invalid results afresh
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= sar_readout_pkg::ST_SLEEP;
			conv_count <= 3'h0;
		end else begin
			state <= next_state;
			if (state != sar_readout_pkg::ST_CONVERT)
				conv_count <= 3'h0;
			else
				conv_count <= conv_count + 3'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			invalid_left <= 2'(`INVALID_RESULTS);
		else if (state == sar_readout_pkg::ST_SLEEP)
			invalid_left <= 2'(`INVALID_RESULTS);
		else if (conv_end && invalid_left != 2'h0)
			invalid_left <= invalid_left - 2'h1;
	end

	// strobes while asleep or not yet sampled are dropped
	assign o_sample_ready = (state == sar_readout_pkg::ST_IDLE)
		&& i_sample_valid;
	assign o_powered = (state != sar_readout_pkg::ST_SLEEP);

	logic [RESULT_BITS-1:0] held_code;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			held_code <= '0;
		else if (start_conv)
			held_code <= i_sample_code;
	end

	// ======================================================
	// result buffer: decouples conversion from readout
	// ======================================================
	wire [RESULT_BITS:0] fifo_in = {invalid_left != 2'h0, held_code};
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic                fifo_out_ready;
	logic [RESULT_BITS:0] fifo_out;

	result_fifo #(
		.WIDTH (RESULT_BITS + 1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_rstn      (i_rstn),
		.i_clear     (state == sar_readout_pkg::ST_SLEEP),
		.i_in_valid  (conv_end),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_out_ready),
		.o_out_data  (fifo_out)
	);

	// ======================================================
	// serial readout
	// ======================================================
	logic [RESULT_BITS-1:0] shreg;
	logic                   loaded;
	logic                   echo;
	logic                   flag_inv;

	wire [RESULT_BITS-1:0] pattern = dual ? `PATTERN_TWO_LANE
		: `PATTERN_ONE_LANE;
	wire [RESULT_BITS-1:0] word = pat ? pattern
		: fifo_out[RESULT_BITS-1:0];
	// newest completion wins: a stale result is lost, not merged
	wire reload = fifo_out_valid && !rclk_edge;
	assign fifo_out_ready = reload;
	wire [1:0] step = dual ? 2'h2 : 2'h1;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			shreg    <= '0;
			loaded   <= 1'b0;
			echo     <= 1'b0;
			flag_inv <= 1'b1;
			o_convert_done <= 1'b0;
		end else begin
			// no completion is announced while asleep beyond the first cycle
			o_convert_done <= reload
				&& (state != sar_readout_pkg::ST_SLEEP);
			if (state == sar_readout_pkg::ST_SLEEP) begin
				loaded <= 1'b0;
				echo   <= 1'b0;
			end else if (reload) begin
				shreg    <= word;
				flag_inv <= fifo_out[RESULT_BITS] && !pat;
				loaded   <= 1'b1;
			end else if (rclk_edge) begin
				echo  <= rclk;
				shreg <= shreg << step;
			end
		end
	end

	// data and echo change in the same cycle for alignment
	assign o_echo_clock_out     = echo;
	assign o_first_lane_out     = loaded && shreg[RESULT_BITS-1];
	assign o_second_lane_out    = loaded && dual
		&& shreg[RESULT_BITS-2];
	assign o_second_lane_enable = !(dual && o_powered);
	assign o_result_invalid     = flag_inv;

	wire unused_ok = fifo_in_ready;
endmodule
`default_nettype wire

// [shared/sar_readout_params.svh]
`ifndef SAR_READOUT_PARAMS_SVH
`define SAR_READOUT_PARAMS_SVH

`define RESULT_BITS       18
`define CONV_TIME_NS      78
`define CLOCK_PERIOD_NS   20
// longest time rounds down
`define CONV_CYCLES       (`CONV_TIME_NS / `CLOCK_PERIOD_NS)
`define INVALID_RESULTS   2
`define PATTERN_ONE_LANE  18'h281FC
`define PATTERN_TWO_LANE  18'h330FC
`define FIFO_DEPTH        32

`endif

// [shared/sar_readout_pkg.sv]
package sar_readout_pkg;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_CONVERT = 3'b010,
		ST_SLEEP   = 3'b100
	} conv_state_e;
endpackage
